// *** hw/relay_output_conditioner.sv ***
// Relay two and three conditioners with their parameter registers.
// Assumes conditions and card-present come from pins (synchronised here)
// and a simple one-cycle register port on the same clock.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Function
// - Output turns on only after the on-delay, 0..60000 ms, default 0.
// - Contactor, brake, no-fault, precharge choices force on-delay 0.
// - Positive polarity, default 1, drives 1 while information true.
// - Negative polarity drives 0 while information true, else 1, but relay three drives 0 while its card is absent.
// - No-fault, brake, precharge, line choices lock polarity positive.
// - Output turns off only after the hold time, 0..9999 ms, default 0.
// - Same four assignments force hold to 0; output contactor keeps it.
// - Relay three exists only when its extension card is present.
// - Choices add brake, line, output contactor, reel, wobble, precharge.
module relay_output_conditioner
    import relay_cond_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    input wire logic relay_two_cond,
    input wire logic relay_three_cond,
    input wire logic card_present,
    output logic relay_two_out,
    output logic relay_three_out
);

    // ------------------------------------------------------------
    // Assignment classes
    // ------------------------------------------------------------
    function automatic logic locked_group(input logic [ASSIGN_W-1:0] a);
        return a == NO_FAULT_ASSIGNMENT ||
            a == BRAKE_CONTACTOR_ASSIGNMENT ||
            a == BUS_PRECHARGE_ASSIGNMENT ||
            a == LINE_CONTACTOR_ASSIGNMENT;
    endfunction

    function automatic logic zero_delay(input logic [ASSIGN_W-1:0] a);
        return locked_group(a) || a == OUTPUT_CONTACTOR_ASSIGNMENT;
    endfunction

    // Upper data bits must be clear, else a large value would wrap in range
    function automatic logic fits(input logic [DATA_W-1:0] d,
        input logic [DELAY_W-1:0] limit);
        return d[DATA_W-1:DELAY_W] == '0 && d[DELAY_W-1:0] <= limit;
    endfunction

    // Clamp a stored config to what its assignment allows
    function automatic relay_cfg_s sanitise(input relay_cfg_s c);
        relay_cfg_s r;
        r = c;
        if (zero_delay(c.assign_sel)) begin
            r.on_delay = DELAY_RESET;
        end
        if (locked_group(c.assign_sel)) begin
            r.polarity = POSITIVE_POLARITY;
            r.off_hold = DELAY_RESET;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync1_q, sync1_d, sync2_q, sync2_d;
    logic present;

    // Card-present gates relay three, so it is sampled like the pins
    always_comb begin
        sync1_d = {card_present, relay_three_cond, relay_two_cond};
        sync2_d = sync1_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    assign present = sync2_q[2];

    // ------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------
    // Free-running, so an N ms delay lasts between N-1 and N ms
    logic [PRE_W-1:0] pre_q, pre_d;
    logic tick_q, tick_d;

    always_comb begin
        tick_d = (pre_q == PRE_LAST);
        pre_d = tick_d ? '0 : pre_q + 17'h00001;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pre_q <= '0;
            tick_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            tick_q <= tick_d;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    relay_cfg_s cfg_q [2];
    relay_cfg_s cfg_d [2];
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [1:0] act;
    logic [1:0] outs;

    generate
        for (genvar i = 0; i < 2; i++) begin : g_cfg
            always_comb begin
                logic hit;
                logic [1:0] fld;
                relay_cfg_s n;
                hit = wr && (addr >= CHAN_STRIDE * ADDR_W'(i)) &&
                    (addr < CHAN_STRIDE * ADDR_W'(i + 1));
                fld = addr[1:0];
                n = cfg_q[i];
                // Relay three writes are dropped without its card
                if (hit && (i == 0 || present)) begin
                    case (fld)
                        FIELD_ASSIGN: begin
                            n.assign_sel = wdata[ASSIGN_W-1:0];
                        end
                        FIELD_ON_DELAY: begin
                            if (fits(wdata, ON_DELAY_MAX_MS) &&
                                !zero_delay(n.assign_sel)) begin
                                n.on_delay = wdata[DELAY_W-1:0];
                            end
                        end
                        FIELD_POLARITY: begin
                            if (!locked_group(n.assign_sel)) begin
                                n.polarity = wdata[0];
                            end
                        end
                        FIELD_OFF_HOLD: begin
                            if (fits(wdata, OFF_HOLD_MAX_MS) &&
                                !locked_group(n.assign_sel)) begin
                                n.off_hold = wdata[DELAY_W-1:0];
                            end
                        end
                        default: n = cfg_q[i];
                    endcase
                end
                cfg_d[i] = sanitise(n);
            end

            always_ff @(posedge clk) begin
                if (rst) begin
                    cfg_q[i] <= CFG_RESET;
                end else begin
                    cfg_q[i] <= cfg_d[i];
                end
            end

            relay_channel u_chan (
                .clk(clk),
                .rst(rst),
                .enable(i == 0 ? 1'b1 : present),
                .ms_tick(tick_q),
                .cond(sync2_q[i]),
                .cfg(cfg_q[i]),
                .relay_out(outs[i]),
                .active(act[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_comb begin
        relay_cfg_s c;
        c = cfg_q[addr[2]];
        rdata_d = '0;
        if (rd) begin
            if (addr == STATUS_ADDR) begin
                // Bit 0 stays clear; coil levels are not reported back
                rdata_d[3] = present;
                rdata_d[2] = act[1];
                rdata_d[1] = act[0];
            end else if (addr < STATUS_ADDR &&
                (!addr[2] || present)) begin
                case (addr[1:0])
                    FIELD_ASSIGN: rdata_d = {26'h0, c.assign_sel};
                    FIELD_ON_DELAY: rdata_d = {16'h0, c.on_delay};
                    FIELD_POLARITY: rdata_d = {31'h0, c.polarity};
                    FIELD_OFF_HOLD: rdata_d = {16'h0, c.off_hold};
                    default: rdata_d = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata = rdata_q;
    assign relay_two_out = outs[0];
    assign relay_three_out = outs[1];

endmodule

// *** hw/relay_cond_pkg.sv ***
// Constants, register map and types for the relay output conditioner.
// Assumes a 100 MHz clock and a millisecond time base derived from it.
package relay_cond_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = CLK_MHZ * TICK_US;
    localparam int unsigned PRE_W = 17;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

    localparam int unsigned DELAY_W = 16;
    localparam logic [DELAY_W-1:0] ON_DELAY_MAX_MS = 16'hea60;
    localparam logic [DELAY_W-1:0] OFF_HOLD_MAX_MS = 16'h270f;
    localparam logic [DELAY_W-1:0] DELAY_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Assignments
    // ------------------------------------------------------------
    localparam int unsigned ASSIGN_W = 6;
    localparam logic [ASSIGN_W-1:0] NONE_ASSIGNMENT = 6'h00;
    localparam logic [ASSIGN_W-1:0] NO_FAULT_ASSIGNMENT = 6'h01;
    localparam logic [ASSIGN_W-1:0] BRAKE_CONTACTOR_ASSIGNMENT = 6'h20;
    localparam logic [ASSIGN_W-1:0] LINE_CONTACTOR_ASSIGNMENT = 6'h21;
    localparam logic [ASSIGN_W-1:0] OUTPUT_CONTACTOR_ASSIGNMENT = 6'h22;
    localparam logic [ASSIGN_W-1:0] END_OF_REEL_ASSIGNMENT = 6'h23;
    localparam logic [ASSIGN_W-1:0] WOBBLE_SYNC_ASSIGNMENT = 6'h24;
    localparam logic [ASSIGN_W-1:0] BUS_PRECHARGE_ASSIGNMENT = 6'h25;

    // ------------------------------------------------------------
    // Registers (word index = address)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 4;
    localparam logic [ADDR_W-1:0] RELAY_TWO_ASSIGN_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] RELAY_TWO_ON_DELAY_ADDR = 4'h1;
    localparam logic [ADDR_W-1:0] RELAY_TWO_POLARITY_ADDR = 4'h2;
    localparam logic [ADDR_W-1:0] RELAY_TWO_OFF_HOLD_ADDR = 4'h3;
    localparam logic [ADDR_W-1:0] RELAY_THREE_ASSIGN_ADDR = 4'h4;
    localparam logic [ADDR_W-1:0] RELAY_THREE_ON_DELAY_ADDR = 4'h5;
    localparam logic [ADDR_W-1:0] RELAY_THREE_POLARITY_ADDR = 4'h6;
    localparam logic [ADDR_W-1:0] RELAY_THREE_OFF_HOLD_ADDR = 4'h7;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h8;
    localparam logic [ADDR_W-1:0] CHAN_STRIDE = 4'h4;
    localparam logic [1:0] FIELD_ASSIGN = 2'h0;
    localparam logic [1:0] FIELD_ON_DELAY = 2'h1;
    localparam logic [1:0] FIELD_POLARITY = 2'h2;
    localparam logic [1:0] FIELD_OFF_HOLD = 2'h3;
    localparam int unsigned DATA_W = 32;
    localparam logic POSITIVE_POLARITY = 1'b1;
    localparam logic negative_polarity = 1'b0;

    typedef struct packed {
        logic [ASSIGN_W-1:0] assign_sel;
        logic [DELAY_W-1:0] on_delay;
        logic polarity;
        logic [DELAY_W-1:0] off_hold;
    } relay_cfg_s;

    localparam relay_cfg_s CFG_RESET = '{
        assign_sel: NONE_ASSIGNMENT,
        on_delay: DELAY_RESET,
        polarity: POSITIVE_POLARITY,
        off_hold: DELAY_RESET
    };

    typedef enum logic [1:0] {
        ST_IDLE_OFF = 2'b00,
        ST_WAIT_ON = 2'b01,
        ST_HELD_ON = 2'b10,
        ST_WAIT_OFF = 2'b11
    } relay_state_e;

endpackage

// *** hw/relay_channel.sv ***
// One relay channel: delay on, hold off, polarity, output flop.
// Assumes a one-cycle tick each millisecond and a synchronised condition.
`timescale 1ns/1ps
module relay_channel
    import relay_cond_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic ms_tick,
    input wire logic cond,
    input wire relay_cfg_s cfg,
    output logic relay_out,
    output logic active
);

    relay_state_e state_q, state_d;
    logic [DELAY_W-1:0] count_q, count_d;
    logic out_q, out_d;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        case (state_q)
            ST_IDLE_OFF: begin
                count_d = DELAY_RESET;
                if (cond) begin
                    // Zero delay acts in the same cycle
                    state_d = (cfg.on_delay == DELAY_RESET) ?
                        ST_HELD_ON : ST_WAIT_ON;
                end
            end
            ST_WAIT_ON: begin
                if (!cond) begin
                    state_d = ST_IDLE_OFF;
                end else if (ms_tick) begin
                    count_d = count_q + 16'h0001;
                    if (count_d >= cfg.on_delay) begin
                        state_d = ST_HELD_ON;
                    end
                end
            end
            ST_HELD_ON: begin
                count_d = DELAY_RESET;
                if (!cond) begin
                    state_d = (cfg.off_hold == DELAY_RESET) ?
                        ST_IDLE_OFF : ST_WAIT_OFF;
                end
            end
            ST_WAIT_OFF: begin
                if (cond) begin
                    state_d = ST_HELD_ON;
                end else if (ms_tick) begin
                    count_d = count_q + 16'h0001;
                    if (count_d >= cfg.off_hold) begin
                        state_d = ST_IDLE_OFF;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE_OFF;
            end
        endcase
        if (!enable) begin
            state_d = ST_IDLE_OFF;
            count_d = DELAY_RESET;
        end
    end

    // Held-on and wait-off states are "information true"; polarity maps them to the pin
    always_comb begin
        if (state_d == ST_HELD_ON || state_d == ST_WAIT_OFF) begin
            out_d = cfg.polarity;
        end else begin
            out_d = ~cfg.polarity;
        end
        if (!enable) begin
            out_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE_OFF;
            count_q <= DELAY_RESET;
            out_q <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            out_q <= out_d;
        end
    end

    assign relay_out = out_q;
    assign active = (state_q == ST_HELD_ON) || (state_q == ST_WAIT_OFF);

endmodule

// *** verification/relay_coil_model.sv ***
// Coil and contact of an external relay on a conditioner output.
// Assumes the coil drive is a clean level on the bench clock.
`timescale 1ns/1ps
module relay_coil_model #(
    parameter int PULL_CYCLES = 0
) (
    input wire logic clk,
    input wire logic coil,
    output logic contact
);
    // ------------------------------------------------------------
    // Contact follows the coil only after a steady pull-in time
    // ------------------------------------------------------------
    int cnt = 0;
    initial contact = 1'b0;
    always @(posedge clk) begin
        if (coil == contact) begin
            cnt <= 0;
        end else if (cnt >= PULL_CYCLES) begin
            contact <= coil;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// *** verification/relay_output_conditioner_asserts.sv ***
// Checker on register read-back and relay three ports of the conditioner.
// Assumes assignment codes are written in the low six data bits.
`timescale 1ns/1ps
module relay_output_conditioner_asserts
    import relay_cond_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic relay_two_cond,
    input wire logic relay_three_cond,
    input wire logic card_present,
    input wire logic relay_two_out,
    input wire logic relay_three_out
);
    // ------------------------------------------------------------
    // Shadow of the relay two assignment, to know which fields lock
    // ------------------------------------------------------------
    logic [ASSIGN_W-1:0] sel_q;
    logic [ASSIGN_W-1:0] sel_d;
    logic grp;
    logic grp_on;
    always_comb begin
        sel_d = sel_q;
        if (wr && addr == RELAY_TWO_ASSIGN_ADDR)
            sel_d = wdata[ASSIGN_W-1:0];
    end
    always_ff @(posedge clk) sel_q <= rst ? NONE_ASSIGNMENT : sel_d;
    assign grp = sel_q inside {NO_FAULT_ASSIGNMENT, BRAKE_CONTACTOR_ASSIGNMENT,
        LINE_CONTACTOR_ASSIGNMENT, BUS_PRECHARGE_ASSIGNMENT};
    assign grp_on = grp || sel_q == OUTPUT_CONTACTOR_ASSIGNMENT;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Locks are judged one cycle late, as forcing lands on the next edge
    a_on_range: assert property (
        wr && addr == RELAY_TWO_ON_DELAY_ADDR && wdata > 32'(ON_DELAY_MAX_MS)
        ##1 rd && addr == RELAY_TWO_ON_DELAY_ADDR
        |=> rdata <= 32'(ON_DELAY_MAX_MS)) else $error("on-delay too large");
    a_on_locked: assert property (
        rd && addr == RELAY_TWO_ON_DELAY_ADDR && grp_on && $past(grp_on)
        |=> rdata == '0) else $error("locked on-delay not zero");
    a_pol_write: assert property (
        wr && addr == RELAY_TWO_POLARITY_ADDR && !grp && !$past(grp)
        && wdata[31:1] == '0 ##1 rd && addr == RELAY_TWO_POLARITY_ADDR
        |=> rdata == $past(wdata, 2)) else $error("polarity write lost");
    a_pol_locked: assert property (
        rd && addr == RELAY_TWO_POLARITY_ADDR && grp && $past(grp)
        |=> rdata == 32'h1) else $error("locked polarity not positive");
    a_hold_range: assert property (
        wr && addr == RELAY_TWO_OFF_HOLD_ADDR && wdata > 32'(OFF_HOLD_MAX_MS)
        ##1 rd && addr == RELAY_TWO_OFF_HOLD_ADDR
        |=> rdata <= 32'(OFF_HOLD_MAX_MS)) else $error("hold out of range");
    a_hold_locked: assert property (
        rd && addr == RELAY_TWO_OFF_HOLD_ADDR && grp && $past(grp)
        |=> rdata == '0) else $error("locked hold not zero");
    a_three_absent: assert property (
        !card_present [*4] |-> !relay_three_out)
        else $error("relay three driven without card");
    a_three_read: assert property (
        !card_present [*4] ##0 rd && addr[3:2] == 2'h1 |=> rdata == '0)
        else $error("relay three readable without card");
    c_three_read: cover property (rd && addr[3:2] == 2'h1 && card_present);
    c_two_on: cover property ($rose(relay_two_out));
    c_locked: cover property (rd && grp && $past(grp));
endmodule
bind relay_output_conditioner relay_output_conditioner_asserts chk_u (
    .clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .relay_two_cond,
    .relay_three_cond, .card_present, .relay_two_out, .relay_three_out);

// *** verification/relay_output_conditioner_tb.sv ***
// Self-checking bench for the relay output conditioner.
// Assumes the 1 ms tick is far longer than any wait here.
`timescale 1ns/1ps
module relay_output_conditioner_tb;
    import relay_cond_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic relay_two_cond = 1'b0;
    logic relay_three_cond = 1'b0;
    logic card_present = 1'b0;
    logic relay_two_out;
    logic relay_three_out;
    logic contact_two;
    logic contact_three;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [ASSIGN_W-1:0] codes [5] = '{6'h01, 6'h20, 6'h21, 6'h25, 6'h22};
    relay_output_conditioner dut_u (.clk, .rst, .addr, .wdata, .wr, .rd,
        .rdata, .relay_two_cond, .relay_three_cond, .card_present,
        .relay_two_out, .relay_three_out);
    relay_coil_model #(.PULL_CYCLES(0)) coil_two_u (.clk,
        .coil(relay_two_out), .contact(contact_two));
    relay_coil_model #(.PULL_CYCLES(3)) coil_three_u (.clk,
        .coil(relay_three_out), .contact(contact_three));
    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (err_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk) begin
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask
    task automatic put(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        rd <= 1'b0;
        addr <= a;
        wdata <= d;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 check("rdata", rdata, e);
        @(posedge clk);
    endtask
    function automatic logic pick(input bit three);
        return three ? relay_three_out : relay_two_out;
    endfunction
    task automatic expect_out(input bit three, input logic e);
        repeat (12) begin
            idle(1);
            #1 if (pick(three) === e) break;
        end
        check("relay output", {31'h0, pick(three)}, {31'h0, e});
        @(posedge clk);
    endtask
    task automatic steady(input bit three, input logic e, input int n);
        int bad;
        bad = 0;
        repeat (n) begin
            idle(1);
            #1 if (pick(three) !== e) bad++;
        end
        check("steady output", bad, 0);
        @(posedge clk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        rchk(RELAY_TWO_ASSIGN_ADDR, 32'h0);
        rchk(RELAY_TWO_ON_DELAY_ADDR, 32'h0);
        rchk(RELAY_TWO_POLARITY_ADDR, 32'h1);
        rchk(RELAY_TWO_OFF_HOLD_ADDR, 32'h0);
    endtask
    task automatic test_polarity();
        put(RELAY_TWO_POLARITY_ADDR, 32'h0);
        rchk(RELAY_TWO_POLARITY_ADDR, 32'h0);
        expect_out(0, 1'b1);
        idle(1);
        check("contact_two", contact_two, 32'h1);
        relay_two_cond <= 1'b1;
        expect_out(0, 1'b0);
        put(RELAY_TWO_POLARITY_ADDR, 32'h1);
        expect_out(0, 1'b1);
        idle(1);
        relay_two_cond <= 1'b0;
        expect_out(0, 1'b0);
    endtask
    task automatic test_range();
        put(RELAY_TWO_ON_DELAY_ADDR, 32'hea60);
        rchk(RELAY_TWO_ON_DELAY_ADDR, 32'hea60);
        put(RELAY_TWO_ON_DELAY_ADDR, 32'hea61);
        rchk(RELAY_TWO_ON_DELAY_ADDR, 32'hea60);
        put(RELAY_TWO_OFF_HOLD_ADDR, 32'h270f);
        rchk(RELAY_TWO_OFF_HOLD_ADDR, 32'h270f);
        put(RELAY_TWO_OFF_HOLD_ADDR, 32'h2710);
        rchk(RELAY_TWO_OFF_HOLD_ADDR, 32'h270f);
    endtask
    task automatic test_cancel();
        put(RELAY_TWO_ON_DELAY_ADDR, 32'h2);
        put(RELAY_TWO_OFF_HOLD_ADDR, 32'h0);
        idle(1);
        relay_two_cond <= 1'b1;
        steady(0, 1'b0, 20);
        relay_two_cond <= 1'b0;
        steady(0, 1'b0, 60);
        put(RELAY_TWO_ON_DELAY_ADDR, 32'h0);
        put(RELAY_TWO_OFF_HOLD_ADDR, 32'h2);
        idle(1);
        relay_two_cond <= 1'b1;
        expect_out(0, 1'b1);
        relay_two_cond <= 1'b0;
        steady(0, 1'b1, 20);
        relay_two_cond <= 1'b1;
        steady(0, 1'b1, 60);
        put(RELAY_TWO_OFF_HOLD_ADDR, 32'h0);
        idle(1);
        relay_two_cond <= 1'b0;
        expect_out(0, 1'b0);
    endtask
    task automatic test_locks();
        logic oc;
        foreach (codes[i]) begin
            oc = codes[i] == OUTPUT_CONTACTOR_ASSIGNMENT;
            put(RELAY_TWO_ASSIGN_ADDR, 32'h0);
            idle(2);
            put(RELAY_TWO_ON_DELAY_ADDR, 32'h7);
            put(RELAY_TWO_POLARITY_ADDR, 32'h0);
            put(RELAY_TWO_OFF_HOLD_ADDR, 32'h5);
            put(RELAY_TWO_ASSIGN_ADDR, 32'(codes[i]));
            idle(2);
            rchk(RELAY_TWO_ASSIGN_ADDR, 32'(codes[i]));
            rchk(RELAY_TWO_ON_DELAY_ADDR, 32'h0);
            rchk(RELAY_TWO_POLARITY_ADDR, oc ? 32'h0 : 32'h1);
            rchk(RELAY_TWO_OFF_HOLD_ADDR, oc ? 32'h5 : 32'h0);
            put(RELAY_TWO_ON_DELAY_ADDR, 32'h3);
            put(RELAY_TWO_POLARITY_ADDR, 32'h0);
            put(RELAY_TWO_OFF_HOLD_ADDR, 32'h9);
            rchk(RELAY_TWO_ON_DELAY_ADDR, 32'h0);
            rchk(RELAY_TWO_POLARITY_ADDR, oc ? 32'h0 : 32'h1);
            rchk(RELAY_TWO_OFF_HOLD_ADDR, oc ? 32'h9 : 32'h0);
        end
        put(RELAY_TWO_ASSIGN_ADDR, 32'(END_OF_REEL_ASSIGNMENT));
        rchk(RELAY_TWO_ASSIGN_ADDR, 32'h23);
        put(RELAY_TWO_ASSIGN_ADDR, 32'(WOBBLE_SYNC_ASSIGNMENT));
        rchk(RELAY_TWO_ASSIGN_ADDR, 32'h24);
    endtask
    task automatic test_three();
        put(RELAY_THREE_POLARITY_ADDR, 32'h0);
        rchk(RELAY_THREE_POLARITY_ADDR, 32'h0);
        relay_three_cond <= 1'b1;
        steady(1, 1'b0, 10);
        card_present <= 1'b1;
        expect_out(1, 1'b1);
        rchk(STATUS_ADDR, 32'hc);
        rchk(RELAY_THREE_POLARITY_ADDR, 32'h1);
        put(RELAY_THREE_POLARITY_ADDR, 32'h0);
        expect_out(1, 1'b0);
        put(RELAY_THREE_POLARITY_ADDR, 32'h1);
        expect_out(1, 1'b1);
        idle(6);
        check("contact_three", contact_three, 32'h1);
        card_present <= 1'b0;
        expect_out(1, 1'b0);
        rchk(STATUS_ADDR, 32'h0);
        rchk(4'h9, 32'h0);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_polarity();
        test_range();
        test_cancel();
        test_locks();
        test_three();
        finish_test();
    end
endmodule
